/* File: rtl/eep_pkg.sv */
package eep_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 8;
  localparam int MEM_DEPTH  = 512;
  localparam int PAGE_W     = 4;
  localparam int CNT_W      = 4;

  // ----------------------------------------------------------------
  // address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_ID  = 4'ha;
  localparam int         DEV_ID_LSB   = 4;
  localparam int         DEV_A2_BIT   = 3;
  localparam int         DEV_A1_BIT   = 2;
  localparam int         DEV_PAGE_BIT = 1;
  localparam int         DEV_RW_BIT   = 0;

  // bit counter value of the ninth (acknowledge) clock
  localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS = 50;
  localparam int WR_TIME_NS    = 5_000_000;
  // longest time: rounds down
  localparam int WR_CYCLES_DEF = WR_TIME_NS / REF_PERIOD_NS;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_DEV,
    LINK_WADDR,
    LINK_WDATA,
    LINK_RDATA
  } eep_link_e;

endpackage

/* File: rtl/eep_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module eep_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // eep_sync

`default_nettype wire

/* File: rtl/eep_slave.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - two select pins match address bits
// - sda sampled on scl rising edge
// - sda output changes on scl falling
// - sda only pulled low or released
// - write lock high blocks array writes
// - undriven select and lock read zero
// - 512 bytes, nine bit byte address
// - page writes up to sixteen bytes
// - self timed program within 5 ms
// - random and sequential reads supported
// - type identifier must be 1010
// - msb first, ninth clock acknowledge
// - controller nack ends read, release sda
// - sda edges while scl high: start/stop
module eep_slave
  import eep_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYCLES_DEF
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic addr_select_low_pin_i,
  input  wire logic addr_select_high_pin_i,
  input  wire logic write_lock_i,
  output logic      write_busy_o
);

  localparam int TMR_W = $clog2(WR_CYCLES + 1);

  // ----------------------------------------------------------------
  // bus condition detection
  // ----------------------------------------------------------------
  logic start_tog;
  logic stop_tog;

  // start on sda fall, scl high
  always_ff @(negedge sda_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      start_tog <= 1'b0;
    else if (scl_i)
      start_tog <= ~start_tog;
  end

  // stop on sda rise, scl high
  always_ff @(posedge sda_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      stop_tog <= 1'b0;
    else if (scl_i)
      stop_tog <= ~stop_tog;
  end

  // ----------------------------------------------------------------
  // pin and busy crossings into the link domain
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       busy_s;
  logic       busy;

  // pull-downs make open pins read low
  eep_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i (scl_i),
    .rst_i (sys_rst_i),
    .d_i   ({write_lock_i, addr_select_high_pin_i, addr_select_low_pin_i}),
    .q_o   (pins_s)
  );

  eep_sync #(
    .WIDTH (1)
  ) u_busy_sync (
    .clk_i (scl_i),
    .rst_i (sys_rst_i),
    .d_i   (busy),
    .q_o   (busy_s)
  );

  // ----------------------------------------------------------------
  // link state, clocked by scl
  // ----------------------------------------------------------------
  eep_link_e         state;
  logic [CNT_W-1:0]  bit_cnt;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] rd_byte;
  logic [ADDR_W-1:0] addr;
  logic              start_seen;
  logic              wrote;
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  logic              dev_match;
  logic              rd_req;
  logic              new_frame;
  logic              ack_slot;
  logic [ADDR_W-1:0] next_rd_addr;
  logic [ADDR_W-1:0] next_wr_addr;

  assign new_frame = start_tog ^ start_seen;
  assign ack_slot  = bit_cnt == ACK_SLOT;
  assign rd_req    = shift[DEV_RW_BIT];

  assign dev_match = shift[DATA_W-1:DEV_ID_LSB] == DEV_TYPE_ID
                  && shift[DEV_A2_BIT] == pins_s[1]
                  && shift[DEV_A1_BIT] == pins_s[0]
                  && !busy_s;

  // sequential reads roll over the whole array
  assign next_rd_addr = ADDR_W'(addr + 9'h001);
  // page writes wrap inside the page
  assign next_wr_addr = {addr[ADDR_W-1:PAGE_W], PAGE_W'(addr[PAGE_W-1:0] + 4'h1)};

  // the start toggle is steady from the scl high time that holds the
  // start until the next rising edge, so it is compared directly here
  always_ff @(posedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      start_seen <= 1'b0;
    else
      start_seen <= start_tog;
  end

  // every bit taken on the rising edge
  always_ff @(posedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state   <= LINK_IDLE;
      bit_cnt <= '0;
      shift   <= BYTE_RST;
    end
    else if (new_frame)
    begin
      state   <= LINK_DEV;
      bit_cnt <= 4'h1;
      shift   <= {shift[DATA_W-2:0], sda_i};
    end
    else if (state != LINK_IDLE && !ack_slot)
    begin
      bit_cnt <= CNT_W'(bit_cnt + 4'h1);
      shift   <= {shift[DATA_W-2:0], sda_i};
    end
    else if (ack_slot)
    begin
      bit_cnt <= '0;
      unique case (state)
        LINK_DEV:
          if (!dev_match)
            state <= LINK_IDLE;
          else if (rd_req)
            state <= LINK_RDATA;
          else
            state <= LINK_WADDR;
        LINK_WADDR:
          state <= LINK_WDATA;
        LINK_WDATA:
          state <= LINK_WDATA;
        LINK_RDATA:
          if (sda_i)
            state <= LINK_IDLE;
        LINK_IDLE:
          state <= LINK_IDLE;
      endcase
    end
  end

  // nine bit byte address, page bit from the address byte
  always_ff @(posedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      addr <= ADDR_RST;
    else if (ack_slot && !new_frame)
    begin
      unique case (state)
        LINK_DEV:
          if (dev_match && !rd_req)
            addr[ADDR_W-1] <= shift[DEV_PAGE_BIT];
        LINK_WADDR:
          addr[DATA_W-1:0] <= shift;
        LINK_WDATA:
          addr <= next_wr_addr;
        LINK_RDATA:
          addr <= next_rd_addr;
        LINK_IDLE:
          addr <= addr;
      endcase
    end
  end

  // 512 by 8 array, nonvolatile so never reset
  always_ff @(posedge scl_i)
  begin
    if (ack_slot && !new_frame && state == LINK_WDATA && !pins_s[2])
      mem[addr] <= shift;
  end

  // load the byte to send; current address or the next one
  always_ff @(posedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rd_byte <= BYTE_RST;
    else if (ack_slot && !new_frame && state == LINK_DEV)
      rd_byte <= mem[addr];
    else if (ack_slot && !new_frame && state == LINK_RDATA)
      rd_byte <= mem[next_rd_addr];
  end

  // marks a frame that stored data; a stop then starts programming
  always_ff @(posedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wrote <= 1'b0;
    else if (new_frame)
      wrote <= 1'b0;
    else if (ack_slot && state == LINK_WDATA && !pins_s[2])
      wrote <= 1'b1;
  end

  // ----------------------------------------------------------------
  // sda driver, launched on the falling edge
  // ----------------------------------------------------------------
  // output changes only on falling scl
  // ack low across the ninth clock high time
  always_ff @(negedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sda_oe_o <= 1'b0;
    else if (ack_slot && state == LINK_DEV)
      sda_oe_o <= dev_match;
    else if (ack_slot && (state == LINK_WADDR || state == LINK_WDATA))
      sda_oe_o <= 1'b1;
    else if (state == LINK_RDATA && !ack_slot)
      sda_oe_o <= ~rd_byte[3'(DATA_W - 1 - int'(bit_cnt))];
    else
      sda_oe_o <= 1'b0;
  end

  // open drain: the level is always low, only the enable moves
  always_ff @(negedge scl_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // programming timer, reference clock domain
  // ----------------------------------------------------------------
  logic [1:0]       evt_s;
  logic             stop_prev;
  logic             stop_evt;
  logic [TMR_W-1:0] tmr;

  eep_sync #(
    .WIDTH (2)
  ) u_evt_sync (
    .clk_i (ref_clk_i),
    .rst_i (sys_rst_i),
    .d_i   ({wrote, stop_tog}),
    .q_o   (evt_s)
  );

  assign stop_evt = evt_s[0] ^ stop_prev;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      stop_prev <= 1'b0;
    else
      stop_prev <= evt_s[0];
  end

  // self timed cycle after the stop that ends a write
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy <= 1'b0;
      tmr  <= '0;
    end
    else if (busy)
    begin
      if (tmr == TMR_W'(WR_CYCLES - 1))
        busy <= 1'b0;
      tmr <= TMR_W'(tmr + 1'b1);
    end
    else if (stop_evt && evt_s[1])
    begin
      busy <= 1'b1;
      tmr  <= '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      write_busy_o <= 1'b0;
    else
      write_busy_o <= busy;
  end

endmodule // eep_slave

`default_nettype wire

/* File: verification/eep_slave_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module eep_slave_assertions #(
  parameter int unsigned WR_CYCLES = 60
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_select_low_pin_i,
  input wire logic addr_select_high_pin_i,
  input wire logic write_lock_i,
  input wire logic write_busy_o
);
  // length of the current programming cycle in reference clocks
  int unsigned bsy_n;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      bsy_n <= 0;
    else
      bsy_n <= write_busy_o ? bsy_n + 1 : 0;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_drive_low_only: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  chk_oe_still_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda enable moved while scl high");
  chk_oe_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda enable moved outside scl low");
  chk_start_by_host: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o)
    else $error("device made a start");
  chk_busy_bound: assert property (bsy_n <= WR_CYCLES)
    else $error("programming cycle too long");
  chk_busy_min: assert property ($rose(write_busy_o) |-> write_busy_o[*8])
    else $error("programming cycle cut short");
  chk_lock_no_prog: assert property (write_lock_i |-> !$rose(write_busy_o))
    else $error("programming while locked");
  chk_prog_idle: assert property ($rose(write_busy_o) |-> !sda_oe_o)
    else $error("programming began mid transfer");

  cover property ($rose(write_busy_o));
  cover property ($rose(sda_oe_o));
  cover property (write_lock_i && $fell(scl_i));
endmodule // eep_slave_assertions

bind eep_slave eep_slave_assertions #(.WR_CYCLES(WR_CYCLES)) eep_slave_assertions_inst (
  .ref_clk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_select_low_pin_i,
  .addr_select_high_pin_i, .write_lock_i, .write_busy_o
);

`default_nettype wire

/* File: verification/eep_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module eep_host_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  localparam int Q = 40;

  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic start();
    sda_oe_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_oe_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b0;
    #Q;
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = !b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, r);
  endtask
endmodule // eep_host_model

`default_nettype wire

/* File: verification/tb_serial_eeprom_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_serial_eeprom_i2c_slave;
  import eep_pkg::*;
  localparam int WRC = 60;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic a_lo_d    = 1'b0;
  logic a_hi_d    = 1'b1;
  logic wl_d      = 1'b0;
  logic scl;
  logic m_oe;
  logic d_o;
  logic d_oe;
  logic busy;
  tri0  a_lo;
  tri0  a_hi;
  tri0  wl;
  wire  sda;
  int   errors    = 0;
  int   cmp_count = 0;
  int   cyc       = 0;

  // undriven pins fall to the pull-down
  assign a_lo = a_lo_d;
  assign a_hi = a_hi_d;
  assign wl   = wl_d;
  assign sda  = !(m_oe || (d_oe && !d_o));
  always #25 ref_clk_i = !ref_clk_i;

  eep_slave #(.WR_CYCLES(WRC)) eep_slave_inst (.ref_clk_i, .sys_rst_i, .scl_i(scl), .sda_i(sda), .sda_o(d_o),
    .sda_oe_o(d_oe), .addr_select_low_pin_i(a_lo), .addr_select_high_pin_i(a_hi), .write_lock_i(wl),
    .write_busy_o(busy));
  eep_host_model eep_host_model_inst (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] dv(input logic p, input logic rd);
    return {DEV_TYPE_ID, a_hi, a_lo, p, rd};
  endfunction

  task automatic sb(input logic [7:0] d, input logic ak);
    logic [7:0] q;
    logic       r;
    eep_host_model_inst.xfer(d, 1'b1, q, r);
    chk1(!r, ak);
  endtask

  task automatic rb(input logic nak, input logic [7:0] e);
    logic [7:0] q;
    logic       r;
    eep_host_model_inst.xfer(8'hff, nak, q, r);
    chk8(q, e);
  endtask

  task automatic rnd(input logic [8:0] a);
    eep_host_model_inst.start();
    sb(dv(a[8], 1'b0), 1'b1);
    sb(a[7:0], 1'b1);
    eep_host_model_inst.start();
    sb(dv(a[8], 1'b1), 1'b1);
  endtask

  // polls the busy flag; a limit that runs out shows as a mismatch
  task automatic wt(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v && n < lim)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    chk1(busy, v);
  endtask

  task automatic t_page_write();
    eep_host_model_inst.start();
    sb(dv(1'b1, 1'b0), 1'b1);
    sb(8'h0e, 1'b1);
    sb(8'h3c, 1'b1);
    sb(8'h25, 1'b1);
    sb(8'h81, 1'b1);
    eep_host_model_inst.stop();
    wt(1'b1, 20);
    eep_host_model_inst.start();
    sb(dv(1'b1, 1'b0), 1'b0);
    eep_host_model_inst.stop();
    wt(1'b0, WRC);
  endtask

  task automatic t_reads();
    rnd(9'h10e);
    rb(1'b0, 8'h3c);
    rb(1'b1, 8'h25);
    eep_host_model_inst.stop();
    rnd(9'h100);
    rb(1'b1, 8'h81);
    eep_host_model_inst.stop();
    rnd(9'h10e);
    rb(1'b1, 8'h3c);
    chk1(d_oe, 1'b0);
    eep_host_model_inst.stop();
    // current address read carries on after the last byte read
    eep_host_model_inst.start();
    sb(dv(1'b1, 1'b1), 1'b1);
    rb(1'b1, 8'h25);
    eep_host_model_inst.stop();
  endtask

  task automatic t_refuse();
    logic [7:0] bad [3];
    bad = '{8'hb8, 8'ha0, 8'hac};
    foreach (bad[i])
    begin
      eep_host_model_inst.start();
      sb(bad[i], 1'b0);
      eep_host_model_inst.stop();
    end
  endtask

  task automatic t_lock();
    @(negedge ref_clk_i);
    wl_d = 1'b1;
    eep_host_model_inst.start();
    sb(dv(1'b1, 1'b0), 1'b1);
    sb(8'h0e, 1'b1);
    sb(8'h5a, 1'b1);
    eep_host_model_inst.stop();
    repeat (20) @(negedge ref_clk_i);
    chk1(busy, 1'b0);
    wl_d = 1'b0;
    rnd(9'h10e);
    rb(1'b1, 8'h3c);
    eep_host_model_inst.stop();
  endtask

  task automatic t_float();
    @(negedge ref_clk_i);
    a_lo_d = 1'bz;
    a_hi_d = 1'bz;
    wl_d = 1'bz;
    eep_host_model_inst.start();
    sb(8'ha0, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h77, 1'b1);
    eep_host_model_inst.stop();
    wt(1'b1, 20);
    wt(1'b0, WRC);
    rnd(9'h000);
    rb(1'b1, 8'h77);
    eep_host_model_inst.stop();
  endtask

  initial
  begin
    // a real rising reset edge: the scl side sees no clock during reset
    #1 sys_rst_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_page_write();
    t_reads();
    t_refuse();
    t_lock();
    t_float();
    wrap_up();
  end

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      wrap_up();
    end
  end
endmodule // tb_serial_eeprom_i2c_slave

`default_nettype wire
